//--- common/sqwt_pkg.sv
// Package for the square-wave interval timer: offsets, fields, codes
package sqwt_pkg;
	// ==========================================================
	// Register offsets (three low address bits decoded)
	localparam logic [2:0] SQWT_OFF_CMD = 3'h0;
	localparam logic [2:0] SQWT_OFF_CNT_LO = 3'h4;
	localparam logic [2:0] SQWT_OFF_CNT_HI = 3'h5;
	// ==========================================================
	// Field positions
	localparam int SQWT_CMD_POS = 6;
	localparam int SQWT_MODE_POS = 14;
	localparam int SQWT_STAT_TMR_POS = 6;
	// ==========================================================
	// Reset values and constants
	localparam logic [13:0] SQWT_TC_VALUE = 14'h0002;
	localparam logic [7:0] SQWT_RD_RESET = 8'h00;
	// Timer command codes
	typedef enum logic [1:0]
	{
		SQWT_CMD_NOP = 2'h0,
		SQWT_CMD_STOP = 2'h1,
		SQWT_CMD_STOP_TC = 2'h2,
		SQWT_CMD_START = 2'h3
	} sqwt_cmd_t;
	// Output modes: bit1 pulse, bit0 continuous
	typedef enum logic [1:0]
	{
		SQWT_MODE_SQ_ONE = 2'h0,
		SQWT_MODE_SQ_CONT = 2'h1,
		SQWT_MODE_PL_ONE = 2'h2,
		SQWT_MODE_PL_CONT = 2'h3
	} sqwt_mode_t;
	// Programmed count length and mode travel together
	typedef struct packed
	{
		sqwt_mode_t mode;
		logic [13:0] length;
	} sqwt_cfg_t;
	// Run state, one-hot
	typedef enum logic [1:0]
	{
		SQWT_ST_IDLE = 2'b01,
		SQWT_ST_RUN = 2'b10
	} sqwt_state_t;
endpackage

//--- dv/square_wave_interval_timer_tb.sv
// Self-checking bench for the interval timer against a queue-free integer model
`timescale 1ns/1ns
module square_wave_interval_timer_tb
	import sqwt_pkg::*;
;
	logic clk_sys_i = 0, rst_n_i = 0, wr_s = 0, rd_s = 0, fire = 0, done, tin, tout;
	logic [7:0] addr_s = 8'h00, wdata_s = 8'h00, rdata, v, v2;
	int err_total = 0, checks = 0, cyc = 0, run = 0, md, ln, k, pv = 0, pm, pl, sm, sl, ml;
	logic [31:0] seed = 32'h48;
	sqwt_timer sqwt_timer_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_s), .wdata_i(wdata_s),
		.wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata), .timer_in_i(tin), .timer_out_o(tout));
	sqwt_pulse_src sqwt_pulse_src_i (.clk_sys_i(clk_sys_i), .fire_i(fire), .done_o(done), .timer_in_o(tin));
	// ==========================================================
	// Clock, 40 ns period, and a hang limit well above the expected run
	initial
	begin
		forever #20 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			err_total++;
			results();
		end
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		checks++;
		if (s !== e)
		begin
			$display("MISMATCH %s expected %h seen %h", n, e, s);
			err_total++;
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ==========================================================
	// Bus cycles: one-cycle strobes, read data in the following cycle only
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		wr_s <= 1'b1;
		addr_s <= a;
		wdata_s <= d;
		@(posedge clk_sys_i);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys_i);
		rd_s <= 1'b1;
		addr_s <= a;
		@(posedge clk_sys_i);
		rd_s <= 1'b0;
		#1 d = rdata;
	endtask
	// ==========================================================
	// Model: staged setup, run state, edge count within the cycle
	task automatic cfg(input int m, input int l);
		wr({5'h00, SQWT_OFF_CNT_LO}, l[7:0]);
		wr({5'h00, SQWT_OFF_CNT_HI}, {m[1:0], l[13:8]});
		sm = m;
		sl = l;
	endtask
	task automatic start();
		wr(8'hc0, 8'hc0); // Upper address bits ignored
		if (run == 0 && sl >= 2)
		begin
			run = 1;
			k = 0;
			md = sm;
			ln = sl;
		end
		else if (run != 0)
		begin
			pv = 1;
			pm = sm;
			pl = sl;
		end
	endtask
	task automatic tick(input bit c);
		int i;
		@(posedge clk_sys_i);
		fire <= 1'b1;
		@(posedge clk_sys_i);
		fire <= 1'b0;
		i = 0;
		do
		begin
			@(posedge clk_sys_i);
			#1 i++;
		end
		while (done !== 1'b1 && i < 40);
		if (run != 0 && ++k == ln)
		begin
			k = 0;
			if (pv != 0)
			begin
				md = pm;
				ln = pl;
				pv = 0;
			end
			else if (md % 2 == 0)
				run = 0;
		end
		ml = (md >= 2) ? (k != ln - 1) : (k < (ln + 1) / 2);
		if (c)
			chk("timer_out", tout, (run == 0) ? 1 : ml[0]);
	endtask
	// ==========================================================
	// Main sequence
	initial
	begin
		repeat (10) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		@(posedge clk_sys_i);
		#1 chk("out_reset", tout, 1);
		tick(1);
		cfg(0, 1);
		start();
		tick(1);
		$display("test idle done");
		for (int t = 0; t < 8; t++)
		begin
			cfg(t % 4, 2 + rnd() % 6);
			start();
			tick(1);
			wr(8'h00, 8'h00);
			rd({5'h1f, SQWT_OFF_CNT_HI}, v);
			chk("mode_bits", v[7:6], sm);
			repeat (2 * sl) tick(1);
			wr(8'h00, 8'h7f);
			run = 0;
			tick(1);
		end
		$display("test modes done");
		cfg(1, 4);
		start();
		tick(1);
		cfg(3, 2);
		repeat (4) tick(1);
		start();
		repeat (8) tick(1);
		wr(8'h00, 8'h40);
		run = 0;
		$display("test restart done");
		cfg(1, 4);
		start();
		tick(1);
		wr(8'h00, 8'h80);
		repeat (6) tick(0);
		chk("stop_tc", tout, 1);
		run = 0;
		rd(8'h06, v);
		chk("unmapped", v, 8'h00);
		$display("test stop done");
		cfg(1, 5);
		start();
		tick(1);
		wr(8'h00, 8'h40);
		rd(8'h04, v);
		rd(8'h05, v2);
		chk("remain", 8'(({v2[5:0], v} >> 1)), 8'((ln + 1) / 2 - k));
		chk("remain_mode", v2[7:6], 1);
		run = 0;
		$display("test remain done");
		cfg(1, 4);
		start();
		tick(1);
		@(posedge clk_sys_i);
		rst_n_i <= 1'b0;
		@(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		run = 0;
		#1 chk("out_rerst", tout, 1);
		repeat (3) tick(1);
		$display("test reset done");
		results();
	end
endmodule // square_wave_interval_timer_tb

//--- dv/sqwt_pulse_src.sv
// Timer input pulse source standing in for the external count feed
`timescale 1ns/1ns
module sqwt_pulse_src
(
	// Clock
	input wire logic clk_sys_i,
	// Request side
	input wire logic fire_i,
	output logic done_o,
	// Timer pin
	output logic timer_in_o
);
	int cnt_q = 0;
	// ==========================================================
	// One pulse per request; line rests low, so no edge outside a request
	// pulses spaced well apart
	always_ff @(posedge clk_sys_i)
	begin
		done_o <= (cnt_q == 1);
		if (fire_i)
			cnt_q <= 18;
		else if (cnt_q > 0)
			cnt_q <= cnt_q - 1;
		timer_in_o <= fire_i || cnt_q > 10; // High 9 clk, then low
	end
endmodule // sqwt_pulse_src

//--- verilog/sqwt_timer.sv
// Square-wave interval timer: 14-bit down counter with command and count registers
`timescale 1ns/1ns
module sqwt_timer
	import sqwt_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Register port
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	// Timer pins
	input wire logic timer_in_i,
	output logic timer_out_o
);
	// ==========================================================
	// Declarations
	sqwt_cfg_t prog_q;
	sqwt_cfg_t act_q;
	sqwt_state_t state_q;
	logic [13:0] cnt_q;
	logic high_half_q;
	logic pend_start_q;
	logic stop_tc_q;
	logic tin_s1_q;
	logic tin_s2_q;
	logic tin_s3_q;
	logic tin_edge;
	logic cmd_wr;
	sqwt_cmd_t cmd_code;
	logic running;
	logic at_tc;
	logic cycle_end;
	logic wrap;
	logic [7:0] rdata_d;

	// Half length, high half takes the extra count on odd lengths
	function automatic logic [13:0] hi_len(input logic [13:0] len);
		hi_len = len - (len >> 1);
	endfunction
	function automatic logic [13:0] lo_len(input logic [13:0] len);
		lo_len = len >> 1;
	endfunction

	// ==========================================================
	// Timer input synchroniser
	// two-stage sync, edge detect
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			tin_s1_q <= 1'b0;
			tin_s2_q <= 1'b0;
			tin_s3_q <= 1'b0;
		end
		else
		begin
			tin_s1_q <= timer_in_i;
			tin_s2_q <= tin_s1_q;
			tin_s3_q <= tin_s2_q;
		end
	end
	// Count on falling edge of the input
	assign tin_edge = tin_s3_q & ~tin_s2_q;

	// ==========================================================
	// Command decode
	// bits 7:6 of command write
	assign cmd_wr = wr_i && (addr_i[2:0] == SQWT_OFF_CMD);
	assign cmd_code = sqwt_cmd_t'(wdata_i[SQWT_CMD_POS +: 2]);
	assign running = (state_q == SQWT_ST_RUN);
	// Counter holds twice-decremented values; the last step lands on terminal count
	assign at_tc = (cnt_q <= SQWT_TC_VALUE);
	// End of a half-cycle on this input edge
	assign wrap = running && tin_edge && at_tc;
	// End of the whole output cycle is the end of the low half
	assign cycle_end = wrap && !high_half_q;

	// ==========================================================
	// Programmed count length registers, no reset value
	// length and mode left undefined by reset
	// length low, mode in top bits
	always_ff @(posedge clk_sys_i)
	begin
		if (wr_i && addr_i[2:0] == SQWT_OFF_CNT_LO)
			prog_q[7:0] <= wdata_i;
		if (wr_i && addr_i[2:0] == SQWT_OFF_CNT_HI)
			prog_q[15:8] <= wdata_i;
	end

	// ==========================================================
	// Run state and pending commands
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			state_q <= SQWT_ST_IDLE;
			pend_start_q <= 1'b0;
			stop_tc_q <= 1'b0;
		end
		else
		begin
			case (state_q)
				SQWT_ST_IDLE:
				begin
					pend_start_q <= 1'b0;
					stop_tc_q <= 1'b0;
					// start from idle; length below two refused
					if (cmd_wr && cmd_code == SQWT_CMD_START && prog_q.length >= SQWT_TC_VALUE)
						state_q <= SQWT_ST_RUN;
				end
				SQWT_ST_RUN:
				begin
					if (cmd_wr && cmd_code == SQWT_CMD_STOP)
					begin
						state_q <= SQWT_ST_IDLE;
					end
					else if (cycle_end && pend_start_q)
					begin
						// new settings take over at terminal count
						pend_start_q <= 1'b0;
						stop_tc_q <= 1'b0;
						if (prog_q.length < SQWT_TC_VALUE)
							state_q <= SQWT_ST_IDLE;
					end
					else if (wrap && (stop_tc_q || (cycle_end && !act_q.mode[0])))
					begin
						// stop at terminal count; single modes end after one cycle
						state_q <= SQWT_ST_IDLE;
					end
					// code 00 falls through unchanged
					// Captured outside the chain: a command landing on a wrap edge is not lost, except a start on a wrap that ends the run
					// Later assignment wins, so the new request beats the clear of the old one
					if (cmd_wr && cmd_code == SQWT_CMD_STOP_TC)
						stop_tc_q <= 1'b1;
					// start needed to adopt new settings
					if (cmd_wr && cmd_code == SQWT_CMD_START)
						pend_start_q <= 1'b1;
				end
				default:
					state_q <= SQWT_ST_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Active settings and down counter; counter has no reset value
	// decrement by two per input pulse
	always_ff @(posedge clk_sys_i)
	begin
		if (!running && cmd_wr && cmd_code == SQWT_CMD_START)
		begin
			act_q <= prog_q;
			cnt_q <= hi_len(prog_q.length) << 1;
			high_half_q <= 1'b1;
		end
		else if (wrap)
		begin
			if (high_half_q)
			begin
				// low half is the shorter one on odd lengths
				cnt_q <= lo_len(act_q.length) << 1;
				high_half_q <= 1'b0;
			end
			else
			begin
				if (pend_start_q)
					act_q <= prog_q;
				cnt_q <= hi_len(pend_start_q ? prog_q.length : act_q.length) << 1;
				high_half_q <= 1'b1;
			end
		end
		else if (running && tin_edge)
			cnt_q <= cnt_q - 14'h0002;
	end

	// ==========================================================
	// Timer output; pulse modes give one low input period at terminal count
	// four modes
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
			timer_out_o <= 1'b1;
		else if (!running)
			timer_out_o <= 1'b1;
		else if (act_q.mode[1])
			timer_out_o <= !(at_tc && !high_half_q);
		else
			timer_out_o <= high_half_q;
	end

	// ==========================================================
	// Read data, one cycle after the strobe
	// live count and mode readback
	always_comb
	begin
		rdata_d = SQWT_RD_RESET;
		case (addr_i[2:0])
			SQWT_OFF_CMD: rdata_d[SQWT_STAT_TMR_POS] = 1'b0;
			SQWT_OFF_CNT_LO: rdata_d = cnt_q[7:0];
			SQWT_OFF_CNT_HI: rdata_d = {act_q.mode, cnt_q[13:8]};
			default: rdata_d = SQWT_RD_RESET;
		endcase
	end
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
			rdata_o <= SQWT_RD_RESET;
		else if (rd_i)
			rdata_o <= rdata_d;
		else
			rdata_o <= SQWT_RD_RESET;
	end

	// ==========================================================
	// Checks
	AST_STOP_NOW: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		running && cmd_wr && cmd_code == SQWT_CMD_STOP |=> state_q == SQWT_ST_IDLE)
		else $error("stop command did not halt");
	AST_START_IDLE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		!running && cmd_wr && cmd_code == SQWT_CMD_START && prog_q.length >= 14'h0002
		|=> running && high_half_q)
		else $error("start did not run");
	AST_NOP_KEEP: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		cmd_wr && cmd_code == SQWT_CMD_NOP && !wrap |=> $stable(state_q))
		else $error("nop changed state");
	AST_IDLE_STOPTC: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		!running && cmd_wr && cmd_code == SQWT_CMD_STOP_TC |=> !running)
		else $error("stop at tc started timer");
	AST_BY_TWO: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		running && tin_edge && !at_tc && !(cmd_wr && cmd_code == SQWT_CMD_STOP)
		|=> cnt_q == $past(cnt_q) - 14'h0002)
		else $error("counter not stepping by two");
	AST_ONE_REFUSED: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		!running && cmd_wr && prog_q.length < 14'h0002 |=> !running)
		else $error("length below two ran");
	AST_RESET_IDLE: assert property (@(posedge clk_sys_i)
		!rst_n_i |=> !running && timer_out_o)
		else $error("not idle after reset");
	AST_SQ_HALF: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		running && !act_q.mode[1] && !(cmd_wr && cmd_code == SQWT_CMD_STOP)
		|=> timer_out_o == $past(high_half_q))
		else $error("square output not following half");
	AST_READBACK: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		rd_i && addr_i[2:0] == SQWT_OFF_CNT_LO |=> rdata_o == $past(cnt_q[7:0]))
		else $error("low count readback wrong");

	// ==========================================================
	// Check helper: input edges seen in the current half-cycle
	// Counted independently of the twice-stepped counter, so a wrong step size shows up
	logic [13:0] half_edges_q;
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
			half_edges_q <= 14'h0000;
		else if ((!running && cmd_wr && cmd_code == SQWT_CMD_START) || wrap)
			half_edges_q <= 14'h0000;
		else if (running && tin_edge)
			half_edges_q <= half_edges_q + 14'h0001;
	end

	AST_HIGH_LEN: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		wrap && high_half_q |-> ((({1'b0, half_edges_q} + 15'h0001) << 1) - {1'b0, act_q.length}) <= 15'h0001)
		else $error("high half edge count wrong");
	AST_LOW_LEN: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		wrap && !high_half_q |-> ({1'b0, act_q.length} - (({1'b0, half_edges_q} + 15'h0001) << 1)) <= 15'h0001)
		else $error("low half edge count wrong");
	AST_STOP_TC_END: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		running && wrap && stop_tc_q && !(cycle_end && pend_start_q) |=> !running)
		else $error("stop after tc did not stop");
	AST_PEND_SWAP: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		running && cycle_end && pend_start_q && !(cmd_wr && cmd_code == SQWT_CMD_STOP)
		&& prog_q.length >= SQWT_TC_VALUE |=> running && act_q == $past(prog_q))
		else $error("pending start not applied");
	AST_RELOAD: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		running && cycle_end && act_q.mode[0] && !pend_start_q && !stop_tc_q
		&& !(cmd_wr && cmd_code == SQWT_CMD_STOP) |=> running && high_half_q)
		else $error("continuous mode did not reload");
	AST_SINGLE_END: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		running && cycle_end && !act_q.mode[0] && !pend_start_q |=> !running)
		else $error("single mode kept running");
	AST_PULSE_LOW: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		running && act_q.mode[1] |=> timer_out_o == !$past(at_tc && !high_half_q))
		else $error("pulse output wrong");
	AST_IDLE_OUT: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		!running |=> timer_out_o)
		else $error("idle output not high");
	AST_LOAD_CFG: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		!running && cmd_wr && cmd_code == SQWT_CMD_START |=> act_q == $past(prog_q))
		else $error("start did not load settings");
	AST_CFG_HOLD: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		running && !(cycle_end && pend_start_q) |=> act_q == $past(act_q))
		else $error("settings changed without start");
	AST_READ_HI: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		rd_i && addr_i[2:0] == SQWT_OFF_CNT_HI |=> rdata_o == {$past(act_q.mode), $past(cnt_q[13:8])})
		else $error("high count readback wrong");
	// read data stands one cycle only
	AST_RD_ZERO: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		!rd_i |=> rdata_o == SQWT_RD_RESET)
		else $error("read data not cleared");
endmodule // sqwt_timer
